// ### rtl/irq_arbiter.sv
`default_nettype none
module irq_arbiter (
   input wire logic i_gie,
   input wire logic i_stack_full,
   input wire logic i_shared_pend,
   input wire logic i_ser_pend,
   input wire logic i_nvm_pend,
   irq_seq_if.arb bus
);
   // stack full blocks the request until the pointer drops; the vector code still shows
   logic ok;
   assign ok = i_gie && !i_stack_full;
   // ack withdraws the request at once so one grant is never taken twice
   assign bus.req = ok && (i_shared_pend || i_ser_pend || i_nvm_pend) && !bus.ack; // see R02 R19
   always_comb begin
      if (i_shared_pend) begin // see R20
         bus.vec = irq_pkg::VEC_SHARED;
      end else if (i_ser_pend) begin
         bus.vec = irq_pkg::VEC_SER;
      end else if (i_nvm_pend) begin
         bus.vec = irq_pkg::VEC_NVM;
      end else begin
         bus.vec = irq_pkg::VEC_NONE;
      end
   end
endmodule
`default_nettype wire

// ### rtl/irq_pkg.sv
`default_nettype none
package irq_pkg;
   localparam int unsigned SRC_COUNT = 5;
   localparam int unsigned VEC_W = 2;
   // source bit positions
   localparam int unsigned SRC_TMR_A = 0;
   localparam int unsigned SRC_TMR_P = 1;
   localparam int unsigned SRC_SER = 2;
   localparam int unsigned SRC_NVM = 3;
   localparam int unsigned SRC_SHARED = 4;
   // vector codes, lower code wins
   localparam logic [1:0] VEC_SHARED = 2'h0;
   localparam logic [1:0] VEC_SER = 2'h1;
   localparam logic [1:0] VEC_NVM = 2'h2;
   localparam logic [1:0] VEC_NONE = 2'h3;
   // reset values
   localparam logic [4:0] FLAGS_RST = 5'h00;
   localparam logic GIE_RST = 1'h0;
   // cycles from acknowledge handshake
   localparam int unsigned ACK_LATENCY = 1;
endpackage
`default_nettype wire

// ### rtl/irq_seq_if.sv
`default_nettype none
interface irq_seq_if;
   logic req;
   logic [1:0] vec;
   logic ack;
   modport arb(output req, output vec, input ack);
   modport top(input req, input vec, output ack);
endinterface
`default_nettype wire

// ### rtl/mcu_interrupt_request_logic.sv
// Overview of operation
// R01: shared vector flag sets when any grouped timer source flag raises.
// R02: shared vector taken only if enabled, stack not full, grouped source requests.
// R03: servicing shared vector clears shared flag and global enable.
// R04: timer source flags stay set after service; software clears them.
// R05: serial flag sets on byte done, address match or bus time-out.
// R06: serial vector needs global enable, serial enable, stack not full.
// R07: serial service clears serial flag and global enable.
// R08: nvm flag sets when a write cycle completes.
// R09: nvm vector needs global enable, nvm enable, stack not full.
// R10: nvm service clears nvm flag and global enable.
// R11: timer has compare-A and compare-P sources, each flag and enable.
// R12: timer match vectors only with global, source, shared enables, stack free.
// R13: any flag rising wakes from sleep or idle regardless of enables.
// R14: software sets a flag before sleep to suppress its wake-up.
// R15: a set flag stays until serviced or cleared by software.
// R16: entry pushes only the program counter.
// R17: interrupt return sets global enable; plain return leaves it clear.
// R18: software should avoid calls inside service code.
// R19: requests during service are recorded but not vectored.
// R20: simultaneous requests resolved by fixed vector priority.
`default_nettype none
module mcu_interrupt_request_logic (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_tmr_a_match,
   input wire logic i_tmr_p_match,
   input wire logic i_ser_byte_done,
   input wire logic i_ser_addr_match,
   input wire logic i_ser_timeout,
   input wire logic i_nvm_write_done,
   input wire logic i_tmr_a_enable,
   input wire logic i_tmr_p_enable,
   input wire logic i_shared_vector_enable,
   input wire logic i_serial_if_interrupt_enable,
   input wire logic i_nvm_write_done_enable,
   input wire logic [4:0] i_flag_clr,
   input wire logic [4:0] i_flag_set,
   input wire logic i_gie_set,
   input wire logic i_gie_clr,
   input wire logic i_stack_full,
   input wire logic i_ack,
   input wire logic i_interrupt_return_instruction,
   input wire logic i_subroutine_return_instruction,
   output logic o_irq_req,
   output logic [1:0] o_irq_vec,
   output logic o_push_pc,
   output logic o_return,
   output logic o_wake,
   output logic o_global_interrupt_enable,
   output logic [4:0] o_flags
);
   typedef struct packed {
      logic [4:0] flags;
      logic gie;
      logic req;
      logic [1:0] vec;
      logic push;
      logic ret;
      logic wake;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic [4:0] raise;
   logic tmr_a_pend;
   logic tmr_p_pend;
   logic shared_pend;
   logic ser_pend;
   logic nvm_pend;
   logic take;
   irq_seq_if seq();

   // hardware events per source, software set folds in
   always_comb begin
      raise = i_flag_set;
      raise[irq_pkg::SRC_TMR_A] = i_tmr_a_match | i_flag_set[irq_pkg::SRC_TMR_A]; // see R11
      raise[irq_pkg::SRC_TMR_P] = i_tmr_p_match | i_flag_set[irq_pkg::SRC_TMR_P]; // see R11
      raise[irq_pkg::SRC_SER] = i_ser_byte_done | i_ser_addr_match | i_ser_timeout
         | i_flag_set[irq_pkg::SRC_SER]; // see R05
      raise[irq_pkg::SRC_NVM] = i_nvm_write_done | i_flag_set[irq_pkg::SRC_NVM]; // see R08
   end

   assign tmr_a_pend = st_reg.flags[irq_pkg::SRC_TMR_A] && i_tmr_a_enable;
   assign tmr_p_pend = st_reg.flags[irq_pkg::SRC_TMR_P] && i_tmr_p_enable;
   // shared vector needs its own flag, its enable and an enabled timer source
   assign shared_pend = st_reg.flags[irq_pkg::SRC_SHARED] && i_shared_vector_enable
      && (tmr_a_pend || tmr_p_pend); // see R12
   assign ser_pend = st_reg.flags[irq_pkg::SRC_SER] && i_serial_if_interrupt_enable; // see R06
   assign nvm_pend = st_reg.flags[irq_pkg::SRC_NVM] && i_nvm_write_done_enable; // see R09

   irq_arbiter u_arb (
      .i_gie(st_reg.gie),
      .i_stack_full(i_stack_full),
      .i_shared_pend(shared_pend),
      .i_ser_pend(ser_pend),
      .i_nvm_pend(nvm_pend),
      .bus(seq.arb)
   );

   // ack only counts against the request shown on the ports
   assign take = i_ack && st_reg.req;
   assign seq.ack = take;

   always_comb begin
      st_next = st_reg;
      st_next.push = 1'b0;
      st_next.ret = 1'b0;
      // flag update: clear first, set wins over a same-cycle clear
      for (int i = 0; i < irq_pkg::SRC_COUNT; i++) begin
         if (i_flag_clr[i]) begin
            st_next.flags[i] = 1'b0; // see R15
         end
      end
      if (take) begin
         unique case (st_reg.vec)
            irq_pkg::VEC_SHARED: st_next.flags[irq_pkg::SRC_SHARED] = 1'b0; // see R03 R04
            irq_pkg::VEC_SER: st_next.flags[irq_pkg::SRC_SER] = 1'b0; // see R07
            irq_pkg::VEC_NVM: st_next.flags[irq_pkg::SRC_NVM] = 1'b0; // see R10
            default: st_next.flags = st_next.flags;
         endcase
         st_next.gie = 1'b0; // see R03 R07 R10
         st_next.push = 1'b1; // see R16
      end
      st_next.flags = st_next.flags | raise; // see R19
      if (raise[irq_pkg::SRC_TMR_A] || raise[irq_pkg::SRC_TMR_P]) begin
         st_next.flags[irq_pkg::SRC_SHARED] = 1'b1; // see R01
      end
      // global enable: software and return instruction
      if (i_gie_clr) begin
         st_next.gie = 1'b0;
      end
      if (i_gie_set && !take) begin
         st_next.gie = 1'b1;
      end
      if (i_interrupt_return_instruction) begin
         st_next.gie = 1'b1; // see R17
         st_next.ret = 1'b1;
      end else if (i_subroutine_return_instruction) begin
         st_next.ret = 1'b1; // see R17
      end
      // wake on any rising flag; already-set flags cannot rise
      st_next.wake = |(st_next.flags & ~st_reg.flags); // see R13 R14
      // request drops for the cycle after ack so the same one is not taken twice
      st_next.req = seq.req; // see R02 R19
      st_next.vec = seq.vec;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         st_reg <= '{flags: irq_pkg::FLAGS_RST, gie: irq_pkg::GIE_RST, req: 1'b0,
                     vec: irq_pkg::VEC_NONE, push: 1'b0, ret: 1'b0, wake: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_irq_req = st_reg.req;
   assign o_irq_vec = st_reg.vec;
   assign o_push_pc = st_reg.push;
   assign o_return = st_reg.ret;
   assign o_wake = st_reg.wake;
   assign o_global_interrupt_enable = st_reg.gie;
   assign o_flags = st_reg.flags;

   a_ser_service_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R07
      (take && st_reg.vec == irq_pkg::VEC_SER && !raise[irq_pkg::SRC_SER] && !i_interrupt_return_instruction)
      |=> (!o_flags[irq_pkg::SRC_SER] && !o_global_interrupt_enable && o_push_pc))
      else $error("serial service did not clear flag and enable");
   a_nvm_service_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R10
      (take && st_reg.vec == irq_pkg::VEC_NVM && !raise[irq_pkg::SRC_NVM] && !i_interrupt_return_instruction)
      |=> (!o_flags[irq_pkg::SRC_NVM] && !o_global_interrupt_enable))
      else $error("nvm service did not clear flag and enable");
   a_shared_keeps_src: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R04
      (take && st_reg.vec == irq_pkg::VEC_SHARED && !(|i_flag_clr))
      |=> (o_flags[1:0] == ($past(st_reg.flags[1:0]) | $past(raise[1:0]))))
      else $error("timer flags changed on shared service");
   a_shared_flag_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R01
      (i_tmr_a_match || i_tmr_p_match) |=> o_flags[irq_pkg::SRC_SHARED])
      else $error("shared flag not set by timer match");
   a_ser_flag_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R05
      (i_ser_byte_done || i_ser_addr_match || i_ser_timeout) |=> o_flags[irq_pkg::SRC_SER])
      else $error("serial flag not set");
   a_nvm_flag_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R08
      i_nvm_write_done |=> o_flags[irq_pkg::SRC_NVM])
      else $error("nvm flag not set");
   a_no_req_blocked: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R02
      (!st_reg.gie || i_stack_full) |=> !o_irq_req)
      else $error("request raised while blocked");
   a_flag_holds: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R15
      (st_reg.flags[irq_pkg::SRC_NVM] && !i_flag_clr[irq_pkg::SRC_NVM] && !take)
      |=> o_flags[irq_pkg::SRC_NVM])
      else $error("nvm flag dropped without service");
   a_wake_on_rise: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R13
      (!st_reg.flags[irq_pkg::SRC_SER] && i_ser_timeout) |=> o_wake)
      else $error("no wake on rising flag");
   a_interrupt_return_instruction_gie: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R17
      (i_interrupt_return_instruction && !i_gie_clr) |=> (o_global_interrupt_enable && o_return))
      else $error("interrupt return did not set enable");
   a_ret_keeps_gie: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R17
      (i_subroutine_return_instruction && !i_interrupt_return_instruction && !st_reg.gie
       && !i_gie_set) |=> !o_global_interrupt_enable)
      else $error("plain return set enable");
   a_priority_pick: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R20
      (shared_pend && ser_pend && st_reg.gie && !i_stack_full && !take) |=> o_irq_vec == irq_pkg::VEC_SHARED)
      else $error("priority order broken");

   // service entry: push pulse with request dropped and enable cleared, then push gone
   sequence s_entry_take;
      take && !i_interrupt_return_instruction;
   endsequence

   sequence s_entry_done;
      (o_push_pc && !o_irq_req && !o_global_interrupt_enable) ##1 !o_push_pc;
   endsequence

   // a timer match in the grant cycle would set the shared flag again, so left out
   sequence s_shared_grant;
      take && st_reg.vec == irq_pkg::VEC_SHARED && !raise[irq_pkg::SRC_TMR_A] && !raise[irq_pkg::SRC_TMR_P]
         && !raise[irq_pkg::SRC_SHARED] && !i_interrupt_return_instruction;
   endsequence

   a_entry_steps: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R16
      s_entry_take
      |=> s_entry_done)
      else $error("service entry steps broken");

   a_push_needs_take: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R16
      !take
      |=> !o_push_pc)
      else $error("push pulse without acknowledge");

   a_take_drops_req: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R19
      take
      |=> !o_irq_req)
      else $error("request stood after acknowledge");

   a_shared_service_clr: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R03
      s_shared_grant
      |=> (!o_flags[irq_pkg::SRC_SHARED] && !o_global_interrupt_enable && o_push_pc))
      else $error("shared service did not clear flag and enable");

   a_idle_no_req: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R02
      (!shared_pend && !ser_pend && !nvm_pend)
      |=> !o_irq_req)
      else $error("request raised with nothing pending");

   a_shared_vector: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R12
      (shared_pend && st_reg.gie && !i_stack_full && !take)
      |=> (o_irq_req && o_irq_vec == irq_pkg::VEC_SHARED))
      else $error("shared vector not requested");

   a_ser_vector: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R06
      (ser_pend && !shared_pend && st_reg.gie && !i_stack_full && !take)
      |=> (o_irq_req && o_irq_vec == irq_pkg::VEC_SER))
      else $error("serial vector not requested");

   a_nvm_vector: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R09
      (nvm_pend && !shared_pend && !ser_pend && st_reg.gie && !i_stack_full && !take)
      |=> (o_irq_req && o_irq_vec == irq_pkg::VEC_NVM))
      else $error("nvm vector not requested");

   a_ser_needs_pend: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R06
      !ser_pend
      |=> o_irq_vec != irq_pkg::VEC_SER)
      else $error("serial vector without enabled flag");

   a_nvm_needs_pend: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R09
      !nvm_pend
      |=> o_irq_vec != irq_pkg::VEC_NVM)
      else $error("nvm vector without enabled flag");

   a_shared_needs_src: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R12
      !(tmr_a_pend || tmr_p_pend)
      |=> o_irq_vec != irq_pkg::VEC_SHARED)
      else $error("shared vector without enabled timer source");

   a_shared_needs_en: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R12
      !i_shared_vector_enable
      |=> o_irq_vec != irq_pkg::VEC_SHARED)
      else $error("shared vector while disabled");

   a_shared_needs_flag: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R02
      !st_reg.flags[irq_pkg::SRC_SHARED]
      |=> o_irq_vec != irq_pkg::VEC_SHARED)
      else $error("shared vector without shared flag");

   a_tmr_a_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R11
      i_tmr_a_match
      |=> o_flags[irq_pkg::SRC_TMR_A])
      else $error("compare-A flag not set");

   a_tmr_p_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R11
      i_tmr_p_match
      |=> o_flags[irq_pkg::SRC_TMR_P])
      else $error("compare-P flag not set");

   a_ser_flag_holds: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R15
      (st_reg.flags[irq_pkg::SRC_SER] && !i_flag_clr[irq_pkg::SRC_SER] && !(take && st_reg.vec == irq_pkg::VEC_SER))
      |=> o_flags[irq_pkg::SRC_SER])
      else $error("serial flag dropped without service");

   a_tmr_flag_holds: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R04
      (st_reg.flags[irq_pkg::SRC_TMR_A] && !i_flag_clr[irq_pkg::SRC_TMR_A])
      |=> o_flags[irq_pkg::SRC_TMR_A])
      else $error("timer flag dropped without software clear");

   a_quiet_no_wake: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R13
      !(|raise)
      |=> !o_wake)
      else $error("wake without a rising flag");

   a_wake_disabled: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R13
      (!st_reg.flags[irq_pkg::SRC_NVM] && !i_nvm_write_done_enable && i_nvm_write_done)
      |=> o_wake)
      else $error("no wake from disabled source");

   a_return_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R17
      (i_interrupt_return_instruction || i_subroutine_return_instruction)
      |=> o_return)
      else $error("return not signalled");

   a_no_stray_return: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R17
      !(i_interrupt_return_instruction || i_subroutine_return_instruction)
      |=> !o_return)
      else $error("return pulse without return");

   a_record_blocked: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R19
      (!st_reg.gie && i_ser_byte_done)
      |=> o_flags[irq_pkg::SRC_SER])
      else $error("request lost while enable cleared");

   a_record_full: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R19
      (i_stack_full && i_nvm_write_done)
      |=> o_flags[irq_pkg::SRC_NVM])
      else $error("request lost while stack full");
endmodule
`default_nettype wire

// ### verification/seq_model.sv
`default_nettype none
module seq_model #(parameter int DEPTH = 2) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_req,
   input wire logic [1:0] i_vec,
   input wire logic i_push,
   input wire logic i_ret,
   input wire logic i_hold,
   input wire logic i_slow,
   output logic o_ack,
   output logic o_full,
   output logic [1:0] o_vec
);
   timeunit 1ns;
   timeprecision 100ps;
   int depth = 0;
   int w = 0;
   assign o_full = depth >= DEPTH;
   initial o_ack = 1'b0;
   // only the return address is stacked, never a call
   always @(posedge i_core_clk) begin
      o_ack <= i_rst_n && i_req && !o_ack && !i_hold && w >= (i_slow ? 3 : 0);
      w <= (i_rst_n && i_req && !o_ack && !i_hold) ? w + 1 : 0;
      if (!i_rst_n) depth <= 0;
      else if (i_push) depth <= depth + 1;
      else if (i_ret) depth <= depth - 1;
      if (i_req && !o_ack) o_vec <= i_vec;
   end
endmodule
`default_nettype wire

// ### verification/tb_mcu_interrupt_request_logic.sv
`default_nettype none
module tb_mcu_interrupt_request_logic;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DEPTH = 2;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] ev = '0;
   logic [4:0] en = '0;
   logic [4:0] fset = '0;
   logic [4:0] fclr = '0;
   logic gset = 1'b0, gclr = 1'b0, interrupt_return_instruction = 1'b0, ret = 1'b0, hold = 1'b1, slow = 1'b0;
   logic ack, full, req, push, rtn, wake, gie;
   logic [1:0] vec, lvec;
   logic [4:0] flags;
   logic [31:0] lfsr = 32'h282A;
   int m_flags = 0, m_gie = 0, m_depth = 0, m_wake = 0;
   int pushes = 0, wake_seen = 0, rets = 0, n_errors = 0, tests_run = 0;
   mcu_interrupt_request_logic dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_tmr_a_match(ev[0]),
      .i_tmr_p_match(ev[1]), .i_ser_byte_done(ev[2]), .i_ser_addr_match(ev[3]), .i_ser_timeout(ev[4]),
      .i_nvm_write_done(ev[5]), .i_tmr_a_enable(en[0]), .i_tmr_p_enable(en[1]), .i_shared_vector_enable(en[2]),
      .i_serial_if_interrupt_enable(en[3]), .i_nvm_write_done_enable(en[4]), .i_flag_clr(fclr), .i_flag_set(fset),
      .i_gie_set(gset), .i_gie_clr(gclr), .i_stack_full(full), .i_ack(ack), .i_interrupt_return_instruction(interrupt_return_instruction),
      .i_subroutine_return_instruction(ret), .o_irq_req(req), .o_irq_vec(vec), .o_push_pc(push), .o_return(rtn),
      .o_wake(wake), .o_global_interrupt_enable(gie), .o_flags(flags));
   seq_model #(.DEPTH(DEPTH)) partner_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_vec(vec),
      .i_push(push), .i_ret(rtn), .i_hold(hold), .i_slow(slow), .o_ack(ack), .o_full(full), .o_vec(lvec));
   task automatic report_and_stop();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [31:0] nxt(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // lower code wins; gating holds the request back but the vector code still shows
   function automatic int exp_vec(input bit gated);
      if (gated && (!m_gie || m_depth >= DEPTH)) return 3;
      if (m_flags[4] && en[2] && (m_flags[0] && en[0] || m_flags[1] && en[1])) return 0;
      if (m_flags[2] && en[3]) return 1;
      if (m_flags[3] && en[4]) return 2;
      return 3;
   endfunction
   task automatic check();
      step(3);
      chk("flags", m_flags[4:0], flags);
      chk("gie", 5'(m_gie), {4'h0, gie});
      chk("req", 5'(exp_vec(1) != 3), {4'h0, req});
      chk("vec", 5'(exp_vec(0)), {3'h0, vec});
      chk("wake", 5'(m_wake), 5'(wake_seen));
   endtask
   // k: 0 gie set, 1 interrupt return, 2 plain return, 3 gie clear
   task automatic drive(input logic [5:0] e, input logic [4:0] s, input logic [4:0] c, input logic [3:0] k);
      logic [4:0] up;
      up = {e[0] | e[1], e[5], |e[4:2], e[1:0]} | s;
      up[4] = up[4] | up[0] | up[1];
      wake_seen = 0;
      rets = 0;
      {ev, fset, fclr, gclr, ret, interrupt_return_instruction, gset} = {e, s, c, k};
      step(1);
      {ev, fset, fclr, gclr, ret, interrupt_return_instruction, gset} = '0;
      m_wake = (up & ~m_flags[4:0]) != 0;
      m_flags = (m_flags & ~c) | up;
      if (k[1] | k[2]) m_depth--;
      if (k[0] | k[1]) m_gie = 1;
      if (k[3]) m_gie = 0;
      check();
      chk("return", 5'(k[1] | k[2]), 5'(rets));
   endtask
   task automatic serve();
      int v;
      int n;
      v = exp_vec(1);
      pushes = 0;
      wake_seen = 0;
      m_wake = 0;
      hold = 1'b0;
      for (n = 0; n < 20 && pushes == 0; n++) step(1);
      hold = 1'b1;
      chk("pushes", 5'(v != 3), 5'(pushes));
      if (v != 3) begin
         chk("taken", 5'(v), {3'h0, lvec});
         m_flags[v == 0 ? 4 : v + 1] = 1'b0;
         m_gie = 0;
         m_depth++;
      end
      check();
   endtask
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (push === 1'b1) pushes <= pushes + 1;
      if (wake === 1'b1) wake_seen <= 1;
      if (rtn === 1'b1) rets <= rets + 1;
   end
   initial begin
      #200000;
      n_errors++;
      report_and_stop();
   end
   initial begin
      step(6);
      rst_n = 1'b1;
      check();
      en = 5'h1F;
      for (int e = 2; e < 6; e++) begin
         drive(6'(1 << e), '0, '0, '0);
         drive('0, '0, '0, 4'h1);
         serve();
         drive('0, '0, '0, 4'h4);
      end
      for (int e = 0; e < 2; e++) begin
         en = 5'h1B;
         drive(6'(1 << e), '0, '0, 4'h1);
         en = 5'h1F;
         serve();
         drive('0, '0, 5'(1 << e), 4'h4);
      end
      slow = 1'b1;
      drive(6'h25, '0, '0, 4'h1);
      serve();
      drive(6'h08, '0, '0, 4'h2);
      serve();
      drive('0, '0, '0, 4'h4);
      drive('0, '0, 5'h01, 4'h1);
      serve();
      drive(6'h04, '0, '0, 4'h1);
      serve();
      drive(6'h20, '0, '0, 4'h1);
      serve();
      drive('0, '0, '0, 4'h2);
      serve();
      drive('0, '0, '0, 4'h4);
      drive('0, '0, '0, 4'h4);
      slow = 1'b0;
      en = '0;
      drive(6'h10, '0, '0, 4'h1);
      drive(6'h04, '0, '0, '0);
      drive('0, 5'h08, 5'h0C, 4'h8);
      drive(6'h20, '0, '0, '0);
      // random traffic stays off the timer flags, whose shared-flag timing is not pinned down
      for (int i = 0; i < 40; i++) begin
         lfsr = nxt(lfsr);
         en = lfsr[4:0];
         drive({lfsr[8:5], 2'h0}, {1'b0, lfsr[10:9], 2'h0}, {1'b0, lfsr[12:11], 2'h0},
            {lfsr[13], 2'h0, !lfsr[13]});
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
